// ---- mcsr_pkg.sv ----
// package: register map, field layout, state codes and carriers for the motor status and command registers
package mcsr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // register offsets as printed, used directly as register addresses
  localparam logic [11:0] OFS_SUPPLY_SPEED   = 12'h0E4;
  localparam logic [11:0] OFS_ALGO_CMD       = 12'h0E6;
  localparam logic [11:0] OFS_SPEED_RATE_SOURCE_SELECT = 12'h0E8;
  localparam logic [11:0] OFS_STATE_SPEED    = 12'h0EA;
  localparam logic [11:0] OFS_BUS_POWER      = 12'h0EC;

  // reset values
  localparam logic [31:0] RST_STATUS   = 32'h0000_0000;
  localparam logic [31:0] RST_COMMAND  = 32'h0000_0000;
  localparam logic [31:0] RST_RATE_SOURCE_SELECT = 32'h0000_0000;

  // supply_speed_status fields
  localparam int unsigned VOLTS_MSB     = 31;
  localparam int unsigned VOLTS_LSB     = 16;
  localparam int unsigned SPDCMD_MSB    = 15;
  localparam int unsigned SPDCMD_LSB    = 1;
  localparam int unsigned SERIAL_ENTRY  = 0;

  // state_speed_status fields
  localparam int unsigned STATE_MSB     = 31;
  localparam int unsigned STATE_LSB     = 28;
  localparam int unsigned SELF_TEST_BIT = 17;
  localparam int unsigned ESPEED_MSB    = 15;
  localparam int unsigned ESPEED_LSB    = 0;

  // bus_power_status fields
  localparam int unsigned AMPS_MSB      = 31;
  localparam int unsigned AMPS_LSB      = 16;
  localparam int unsigned WATTS_MSB     = 15;
  localparam int unsigned WATTS_LSB     = 0;

  // algorithm_command fields
  localparam int unsigned CMD_NV_SAVE   = 31;
  localparam int unsigned CMD_NV_LOAD   = 30;
  localparam int unsigned CMD_FLT_CLR   = 29;
  localparam int unsigned CMD_RETRY_CLR = 28;
  localparam int unsigned KEY_MSB       = 27;
  localparam int unsigned KEY_LSB       = 20;
  localparam int unsigned CMD_ALIVE     = 0;

  // speed_rate_source_select_control fields
  localparam int unsigned OVR_SPD_MSB   = 30;
  localparam int unsigned OVR_SPD_LSB   = 16;
  localparam int unsigned OVR_SEL_BIT   = 15;

  // unlock key for a nonvolatile save; value is arbitrary
  localparam logic [7:0] NV_UNLOCK_KEY = 8'hA5;

  // number of command trigger outputs
  localparam int unsigned N_TRIG = 5;

  typedef enum logic [3:0] {
    ST_SYSTEM_IDLE = 4'h0,
    ST_MOTOR_START = 4'h1,
    ST_MOTOR_RUN   = 4'h2,
    ST_SYSTEM_INIT = 4'h3,
    ST_POS_DETECT  = 4'h4,
    ST_ALIGN       = 4'h5,
    ST_MOTOR_IDLE  = 4'h6,
    ST_MOTOR_STOP  = 4'h7,
    ST_FAULT       = 4'h8,
    ST_DIRECTION   = 4'h9,
    ST_SENSOR_ALGN = 4'hA,
    ST_CALIBRATE   = 4'hC,
    ST_BRAKING     = 4'hD,
    ST_NOT_APPL    = 4'hF
  } mcsr_state_e;

  // live values from the motor control core
  typedef struct packed {
    logic [15:0] supply_volts;
    logic [14:0] speed_cmd;
    logic        serial_entry;
    logic [3:0]  ctrl_state;
    logic        self_test_fail;
    logic [15:0] elec_speed;
    logic [15:0] bus_amps;
    logic [15:0] input_watts;
  } mcsr_status_s;

  // one-cycle command strobes toward the core
  typedef struct packed {
    logic nv_save;
    logic nv_load;
    logic fault_clear;
    logic retry_clear;
    logic host_alive;
  } mcsr_cmd_s;

endpackage

// ---- mcsr_pulse.sv ----
// module: registered one-cycle strobes, one per trigger bit
`timescale 1ns/1ps
module mcsr_pulse #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  // trigger requests, one cycle each
  input  wire logic [W-1:0] trig_i,
  // strobes, one cycle each
  output logic      [W-1:0] pulse_o
);

  logic [W-1:0] pulse_q;

  // each strobe lasts exactly one cycle because the request is itself one cycle
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= trig_i;
    end
  end

  assign pulse_o = pulse_q;

endmodule

// ---- mcsr_regs.sv ----
// module: status and command register bank of the sensorless motor controller
//
// Contract
// (R01) supply volts in bits 31-16, volts = value/10
// (R02) fifteen-bit decoded speed command in bits 15-1
// (R03) serial-entry bit set only after pin sequence
// (R04) state field bits 31-28, codes 0-7
// (R05) codes 8,9,A,C,D,F; B and E unassigned
// (R06) self-test fail flag in bit 17
// (R07) electrical speed, tenth hertz, bits 15-0
// (R08) bus current bits 31-16, amps = value/256
// (R09) input power bits 15-0, watts = value/64
// (R10) bit 31 write saves shadow to nonvolatile
// (R11) bit 30 write reloads shadow from nonvolatile
// (R12) bit 29 write clears all latched faults
// (R13) bit 28 write clears lock retry counters
// (R14) save refused unless key accompanies it
// (R15) host alive bit auto-clears after write
// (R16) host leaves unlisted offsets untouched; the host model never writes them but still reads them
// (R17) all registers reset zero, status read-only
// (R18) rate_source_select speed 30-16, bit 15 selects source
// (R19) triggers pulse once per write, read zero
`timescale 1ns/1ps
module mcsr_regs (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  // register port from the serial target front end
  input  wire logic                      req_valid_i,
  input  wire logic                      req_write_i,
  input  wire logic [11:0]               req_addr_i,
  input  wire logic [31:0]               req_wdata_i,
  output logic                           rsp_valid_o,
  output logic                           rsp_error_o,
  output logic      [31:0]               rsp_rdata_o,
  // live values from the motor control core
  input  wire mcsr_pkg::mcsr_status_s    status_i,
  // command strobes and settings toward the core
  output mcsr_pkg::mcsr_cmd_s            cmd_o,
  output logic                           nv_save_refused_o,
  output logic                           rate_source_select_o,
  output logic      [14:0]               speed_rate_source_select_o
);

  // snapshot of the core values, so a read sees one consistent word
  logic [15:0] volts_q;
  logic [14:0] speed_cmd_q;
  logic        serial_entry_q;
  logic [3:0]  state_q;
  logic        self_test_q;
  logic [15:0] elec_speed_q;
  logic [15:0] amps_q;
  logic [15:0] watts_q;
  logic [31:0] supply_speed_w;
  logic [31:0] state_speed_w;
  logic [31:0] bus_power_w;

  logic [14:0] ovr_speed_q;
  logic        ovr_select_q;
  logic [31:0] rate_source_select_w;
  logic        refused_q;
  logic        rsp_valid_q;
  logic        rsp_error_q;
  logic [31:0] rsp_rdata_q;
  logic [31:0] rdata_d;
  logic        hit_d;

  logic        rd_req;
  logic        wr_req;
  logic        sel_supply;
  logic        sel_cmd;
  logic        sel_ovr;
  logic        sel_state;
  logic        sel_bus;
  logic        wr_cmd;
  logic        wr_ovr;
  logic        key_ok;
  logic        save_refused;
  logic        refuse_clr;
  logic [mcsr_pkg::N_TRIG-1:0] trig_d;
  logic [mcsr_pkg::N_TRIG-1:0] pulse;

  mcsr_pkg::mcsr_state_e state_rep;

  // unassigned or unknown state codes are shown as not applicable
  always_comb begin
    unique case (status_i.ctrl_state)
      4'h0: state_rep = mcsr_pkg::ST_SYSTEM_IDLE; // (R04)
      4'h1: state_rep = mcsr_pkg::ST_MOTOR_START;
      4'h2: state_rep = mcsr_pkg::ST_MOTOR_RUN;
      4'h3: state_rep = mcsr_pkg::ST_SYSTEM_INIT;
      4'h4: state_rep = mcsr_pkg::ST_POS_DETECT;
      4'h5: state_rep = mcsr_pkg::ST_ALIGN;
      4'h6: state_rep = mcsr_pkg::ST_MOTOR_IDLE;
      4'h7: state_rep = mcsr_pkg::ST_MOTOR_STOP;
      4'h8: state_rep = mcsr_pkg::ST_FAULT; // (R05)
      4'h9: state_rep = mcsr_pkg::ST_DIRECTION;
      4'hA: state_rep = mcsr_pkg::ST_SENSOR_ALGN;
      4'hC: state_rep = mcsr_pkg::ST_CALIBRATE;
      4'hD: state_rep = mcsr_pkg::ST_BRAKING;
      default: state_rep = mcsr_pkg::ST_NOT_APPL; // (R05)
    endcase
  end

  // status fields only ever load from the core, never from the host
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      volts_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::VOLTS_MSB:mcsr_pkg::VOLTS_LSB]; // (R17)
    end else begin
      volts_q <= status_i.supply_volts;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_cmd_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::SPDCMD_MSB:mcsr_pkg::SPDCMD_LSB]; // (R17)
    end else begin
      speed_cmd_q <= status_i.speed_cmd;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_entry_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::SERIAL_ENTRY]; // (R17)
    end else begin
      serial_entry_q <= status_i.serial_entry;
    end
  end

  // the decoded code is stored, so a read never shows an unassigned code
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::STATE_MSB:mcsr_pkg::STATE_LSB]; // (R17)
    end else begin
      state_q <= state_rep;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      self_test_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::SELF_TEST_BIT]; // (R17)
    end else begin
      self_test_q <= status_i.self_test_fail;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      elec_speed_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::ESPEED_MSB:mcsr_pkg::ESPEED_LSB]; // (R17)
    end else begin
      elec_speed_q <= status_i.elec_speed;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amps_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::AMPS_MSB:mcsr_pkg::AMPS_LSB]; // (R17)
    end else begin
      amps_q <= status_i.bus_amps;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watts_q <= mcsr_pkg::RST_STATUS[mcsr_pkg::WATTS_MSB:mcsr_pkg::WATTS_LSB]; // (R17)
    end else begin
      watts_q <= status_i.input_watts;
    end
  end

  // pack the status words; reserved bits stay zero
  always_comb begin
    supply_speed_w = mcsr_pkg::RST_STATUS;
    supply_speed_w[mcsr_pkg::VOLTS_MSB:mcsr_pkg::VOLTS_LSB] = volts_q; // (R01)
    supply_speed_w[mcsr_pkg::SPDCMD_MSB:mcsr_pkg::SPDCMD_LSB] = speed_cmd_q; // (R02)
    supply_speed_w[mcsr_pkg::SERIAL_ENTRY] = serial_entry_q; // (R03)
  end

  always_comb begin
    state_speed_w = mcsr_pkg::RST_STATUS;
    state_speed_w[mcsr_pkg::STATE_MSB:mcsr_pkg::STATE_LSB] = state_q; // (R04)
    state_speed_w[mcsr_pkg::SELF_TEST_BIT] = self_test_q; // (R06)
    state_speed_w[mcsr_pkg::ESPEED_MSB:mcsr_pkg::ESPEED_LSB] = elec_speed_q; // (R07)
  end

  always_comb begin
    bus_power_w = mcsr_pkg::RST_STATUS;
    bus_power_w[mcsr_pkg::AMPS_MSB:mcsr_pkg::AMPS_LSB] = amps_q; // (R08)
    bus_power_w[mcsr_pkg::WATTS_MSB:mcsr_pkg::WATTS_LSB] = watts_q; // (R09)
  end

  // address and direction decode, shared by the write and read paths
  assign rd_req     = req_valid_i && !req_write_i;
  assign wr_req     = req_valid_i && req_write_i;
  assign sel_supply = (req_addr_i == mcsr_pkg::OFS_SUPPLY_SPEED);
  assign sel_cmd    = (req_addr_i == mcsr_pkg::OFS_ALGO_CMD);
  assign sel_ovr    = (req_addr_i == mcsr_pkg::OFS_SPEED_RATE_SOURCE_SELECT);
  assign sel_state  = (req_addr_i == mcsr_pkg::OFS_STATE_SPEED);
  assign sel_bus    = (req_addr_i == mcsr_pkg::OFS_BUS_POWER);

  // writes to the status words find no target here and are dropped
  assign wr_cmd = wr_req && sel_cmd;
  assign wr_ovr = wr_req && sel_ovr;

  // key must travel in the same write as the save bit
  assign key_ok = (req_wdata_i[mcsr_pkg::KEY_MSB:mcsr_pkg::KEY_LSB] == mcsr_pkg::NV_UNLOCK_KEY); // (R14)
  assign save_refused = wr_cmd && req_wdata_i[mcsr_pkg::CMD_NV_SAVE] && !key_ok; // (R14)

  // triggers are requested for exactly the cycle of the write
  always_comb begin
    trig_d = '0;
    if (wr_cmd) begin
      trig_d[4] = req_wdata_i[mcsr_pkg::CMD_NV_SAVE] && key_ok; // (R10)
      trig_d[3] = req_wdata_i[mcsr_pkg::CMD_NV_LOAD]; // (R11)
      trig_d[2] = req_wdata_i[mcsr_pkg::CMD_FLT_CLR]; // (R12)
      trig_d[1] = req_wdata_i[mcsr_pkg::CMD_RETRY_CLR]; // (R13)
      trig_d[0] = req_wdata_i[mcsr_pkg::CMD_ALIVE]; // (R15)
    end
  end

  // command bits are never stored, so they fall back to zero by themselves
  mcsr_pulse #(
    .W (mcsr_pkg::N_TRIG)
  ) u_pulse (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .trig_i  (trig_d),
    .pulse_o (pulse)
  );

  assign cmd_o.nv_save     = pulse[4]; // (R19)
  assign cmd_o.nv_load     = pulse[3];
  assign cmd_o.fault_clear = pulse[2];
  assign cmd_o.retry_clear = pulse[1];
  assign cmd_o.host_alive  = pulse[0]; // (R15)

  // an accepted save or a fault clear withdraws an old refusal
  assign refuse_clr = trig_d[4] || trig_d[2];

  // refusal flag: a new refusal wins over a clear in the same write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refused_q <= 1'b0;
    end else if (save_refused) begin
      refused_q <= 1'b1; // (R14)
    end else if (refuse_clr) begin
      refused_q <= 1'b0;
    end
  end

  assign nv_save_refused_o = refused_q;

  // speed rate_source_select setting; bit 31 is write-only reserved and not kept
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_speed_q <= mcsr_pkg::RST_RATE_SOURCE_SELECT[mcsr_pkg::OVR_SPD_MSB:mcsr_pkg::OVR_SPD_LSB]; // (R17)
    end else if (wr_ovr) begin
      ovr_speed_q <= req_wdata_i[mcsr_pkg::OVR_SPD_MSB:mcsr_pkg::OVR_SPD_LSB]; // (R18)
    end
  end

  // the source select drives the core directly, so it has a flop of its own
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovr_select_q <= mcsr_pkg::RST_RATE_SOURCE_SELECT[mcsr_pkg::OVR_SEL_BIT]; // (R17)
    end else if (wr_ovr) begin
      ovr_select_q <= req_wdata_i[mcsr_pkg::OVR_SEL_BIT]; // (R18)
    end
  end

  // readback word; bits that are not kept read as zero
  always_comb begin
    rate_source_select_w = mcsr_pkg::RST_RATE_SOURCE_SELECT;
    rate_source_select_w[mcsr_pkg::OVR_SPD_MSB:mcsr_pkg::OVR_SPD_LSB] = ovr_speed_q;
    rate_source_select_w[mcsr_pkg::OVR_SEL_BIT] = ovr_select_q;
  end

  assign rate_source_select_o = ovr_select_q; // (R18)
  assign speed_rate_source_select_o     = ovr_speed_q;

  // read mux; command word reads zero, unmapped offsets answer with error
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (sel_supply) begin
      rdata_d = supply_speed_w;
    end
    if (sel_cmd) begin
      rdata_d = mcsr_pkg::RST_COMMAND; // (R19)
    end
    if (sel_ovr) begin
      rdata_d = rate_source_select_w;
    end
    if (sel_state) begin
      rdata_d = state_speed_w;
    end
    if (sel_bus) begin
      rdata_d = bus_power_w;
    end
  end

  // an offset outside the map is answered with an error and changes nothing
  assign hit_d = sel_supply || sel_cmd || sel_ovr || sel_state || sel_bus;

  // one answer per request, one cycle later, whatever the offset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_error_q <= 1'b0;
    end else begin
      rsp_error_q <= req_valid_i && !hit_d;
    end
  end

  // writes answer with zero data so a stale read word never leaks out
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_rdata_q <= 32'h0000_0000;
    end else if (rd_req) begin
      rsp_rdata_q <= rdata_d; // (R17)
    end else begin
      rsp_rdata_q <= 32'h0000_0000;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_error_o = rsp_error_q;
  assign rsp_rdata_o = rsp_rdata_q;

endmodule

// ---- mcsr_regs_checker.sv ----
// checker: port-level properties of the register bank
`timescale 1ns/1ps
module mcsr_regs_checker (
  // clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  // register port
  input  wire logic                   req_valid_i,
  input  wire logic                   req_write_i,
  input  wire logic [11:0]            req_addr_i,
  input  wire logic [31:0]            req_wdata_i,
  input  wire logic                   rsp_valid_o,
  input  wire logic                   rsp_error_o,
  input  wire logic [31:0]            rsp_rdata_o,
  // core side
  input  wire mcsr_pkg::mcsr_status_s status_i,
  input  wire mcsr_pkg::mcsr_cmd_s    cmd_o,
  input  wire logic                   nv_save_refused_o,
  input  wire logic                   rate_source_select_o,
  input  wire logic [14:0]            speed_rate_source_select_o
);
  logic        alive_req_q;
  logic [31:0] wdata_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alive_req_q <= 1'h0;
    end else begin
      alive_req_q <= req_valid_i && req_write_i && req_addr_i == mcsr_pkg::OFS_ALGO_CMD && req_wdata_i[0];
    end
  end
  // write data of the previous cycle, request or not, for the rate_source_select output check
  always_ff @(posedge clock_i) begin
    wdata_q <= req_wdata_i;
  end
  sequence s_cmd;
    req_valid_i && req_write_i && req_addr_i == mcsr_pkg::OFS_ALGO_CMD;
  endsequence
  sequence s_keyed;
    s_cmd ##0 (req_wdata_i[31] && req_wdata_i[27:20] == mcsr_pkg::NV_UNLOCK_KEY);
  endsequence
  property p_save; s_keyed |=> cmd_o.nv_save; endproperty
  property p_refuse;
    s_cmd ##0 (req_wdata_i[31] && req_wdata_i[27:20] != mcsr_pkg::NV_UNLOCK_KEY) |=> !cmd_o.nv_save && nv_save_refused_o;
  endproperty
  property p_load; s_cmd ##0 req_wdata_i[30] |=> cmd_o.nv_load; endproperty
  property p_clr; s_cmd ##0 req_wdata_i[29] |=> cmd_o.fault_clear; endproperty
  property p_retry; s_cmd ##0 req_wdata_i[28] |=> cmd_o.retry_clear; endproperty
  property p_alive; s_cmd ##0 req_wdata_i[0] |=> cmd_o.host_alive; endproperty
  // a second pulse without a second write would look like a live host
  property p_one; cmd_o.host_alive |-> alive_req_q; endproperty
  property p_e6rd;
    req_valid_i && !req_write_i && req_addr_i == mcsr_pkg::OFS_ALGO_CMD |=> rsp_valid_o && rsp_rdata_o == 32'h0;
  endproperty
  property p_ovr;
    req_valid_i && req_write_i && req_addr_i == mcsr_pkg::OFS_SPEED_RATE_SOURCE_SELECT
      |=> speed_rate_source_select_o == wdata_q[30:16] && rate_source_select_o == wdata_q[15];
  endproperty
  property p_ro;
    req_valid_i && req_write_i && req_addr_i == mcsr_pkg::OFS_SUPPLY_SPEED |=> rsp_valid_o && !rsp_error_o;
  endproperty
  a_save: assert property (p_save) else $error("keyed save gave no strobe");
  a_refuse: assert property (p_refuse) else $error("unkeyed save not refused");
  a_load: assert property (p_load) else $error("load strobe missing");
  a_clr: assert property (p_clr) else $error("fault clear strobe missing");
  a_retry: assert property (p_retry) else $error("retry clear strobe missing");
  a_alive: assert property (p_alive) else $error("alive strobe missing");
  a_one: assert property (p_one) else $error("alive strobe without write");
  a_e6rd: assert property (p_e6rd) else $error("command word read not zero");
  a_ovr: assert property (p_ovr) else $error("rate_source_select fields not taken");
  a_ro: assert property (p_ro) else $error("status write answered wrongly");
endmodule
bind mcsr_regs mcsr_regs_checker u_chk (.clock_i, .rst_n_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
  .rsp_valid_o, .rsp_error_o, .rsp_rdata_o, .status_i, .cmd_o, .nv_save_refused_o, .rate_source_select_o,
  .speed_rate_source_select_o);

// ---- mcsr_host.sv ----
// partner model: host side of the register port
`timescale 1ns/1ps
module mcsr_host (
  // clock
  input  wire logic        clock_i,
  // request
  output logic             req_valid_o,
  output logic             req_write_o,
  output logic      [11:0] req_addr_o,
  output logic      [31:0] req_wdata_o,
  // answer
  input  wire logic        rsp_error_i,
  input  wire logic [31:0] rsp_rdata_i
);
  initial begin
    req_valid_o = 1'h0;
    req_write_o = 1'h0;
    req_addr_o = 12'h0;
    req_wdata_o = 32'h0;
  end
  // one whole word per request; released lines go to the inverse, not the old value
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic er);
    @(negedge clock_i);
    req_valid_o = 1'h1;
    // unlisted offsets may be read but never written
    req_write_o = w && (a inside {12'h0E4, 12'h0E6, 12'h0E8, 12'h0EA, 12'h0EC});
    req_addr_o = a;
    req_wdata_o = d;
    @(negedge clock_i);
    rd = rsp_rdata_i;
    er = rsp_error_i;
    req_valid_o = 1'h0;
    req_write_o = ~w;
    req_addr_o = ~a;
    req_wdata_o = ~d;
  endtask
endmodule

// ---- tb_mcsr_regs.sv ----
// testbench: register bank self-check
`timescale 1ns/1ps
module tb_mcsr_regs;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] rd;
    logic        er;
    logic [4:0]  cm;
  } mcsr_row_s;
  logic                   clock_i;
  logic                   rst_n_i;
  logic                   req_valid;
  logic                   req_write;
  logic [11:0]            req_addr;
  logic [31:0]            req_wdata;
  logic                   rsp_valid;
  logic                   rsp_error;
  logic [31:0]            rsp_rdata;
  mcsr_pkg::mcsr_status_s status_i;
  mcsr_pkg::mcsr_cmd_s    cmd_o;
  logic                   refused;
  logic                   rate_sel;
  logic [14:0]            spd;
  logic [31:0]            rd;
  logic                   er;
  int                     n_errors;
  int                     checks_done;
  mcsr_row_s              rows [14] = '{
    '{1'h0, 12'h0E4, 32'h0, 32'h01F4FFFF, 1'h0, 5'h00},
    '{1'h0, 12'h0EA, 32'h0, 32'h80021234, 1'h0, 5'h00},
    '{1'h0, 12'h0EC, 32'h0, 32'hABCD0040, 1'h0, 5'h00},
    '{1'h1, 12'h0E6, 32'h8A500000, 32'h0, 1'h0, 5'h10},
    '{1'h1, 12'h0E6, 32'h40000000, 32'h0, 1'h0, 5'h08},
    '{1'h1, 12'h0E6, 32'h20000000, 32'h0, 1'h0, 5'h04},
    '{1'h1, 12'h0E6, 32'h10000000, 32'h0, 1'h0, 5'h02},
    '{1'h1, 12'h0E6, 32'h00000001, 32'h0, 1'h0, 5'h01},
    '{1'h0, 12'h0E6, 32'h0, 32'h0, 1'h0, 5'h00},
    '{1'h1, 12'h0E8, 32'hFFFF8000, 32'h0, 1'h0, 5'h00},
    '{1'h0, 12'h0E8, 32'h0, 32'h7FFF8000, 1'h0, 5'h00},
    '{1'h1, 12'h0E4, 32'hFFFFFFFF, 32'h0, 1'h0, 5'h00},
    '{1'h0, 12'h0E4, 32'h0, 32'h01F4FFFF, 1'h0, 5'h00},
    '{1'h0, 12'h0E2, 32'h0, 32'h0, 1'h1, 5'h00}
  };
  mcsr_regs u_mcsr_regs (.clock_i, .rst_n_i, .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid), .rsp_error_o(rsp_error),
    .rsp_rdata_o(rsp_rdata), .status_i, .cmd_o, .nv_save_refused_o(refused),
    .rate_source_select_o(rate_sel), .speed_rate_source_select_o(spd));
  mcsr_host u_mcsr_host (.clock_i, .req_valid_o(req_valid), .req_write_o(req_write), .req_addr_o(req_addr),
    .req_wdata_o(req_wdata), .rsp_error_i(rsp_error), .rsp_rdata_i(rsp_rdata));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    n_errors = 0;
    checks_done = 0;
    rst_n_i = 1'h0;
    status_i = {16'h01F4, 15'h7FFF, 1'h1, 4'h8, 1'h1, 16'h1234, 16'hABCD, 16'h0040};
    repeat (3) @(negedge clock_i);
    chk("idle", {rsp_valid, cmd_o, spd, 11'h0}, 32'h0);
    rst_n_i = 1'h1;
    foreach (rows[i]) begin
      u_mcsr_host.access(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk("rdata", rd, rows[i].rd);
      chk("error", {31'h0, er}, {31'h0, rows[i].er});
      chk("valid", {31'h0, rsp_valid}, 32'h1);
      chk("strobes", {27'h0, cmd_o}, {27'h0, rows[i].cm});
    end
    // every state code, the unassigned ones included
    for (int c = 0; c < 16; c++) begin
      status_i.ctrl_state = 4'(c);
      u_mcsr_host.access(1'h0, mcsr_pkg::OFS_STATE_SPEED, 32'h0, rd, er);
      chk("state", rd, {(4'(c) == 4'hB || 4'(c) == 4'hE) ? 4'hF : 4'(c), 28'h0021234});
    end
    // the zero side of the entry flag and of the self-test flag
    status_i.serial_entry = 1'h0;
    status_i.self_test_fail = 1'h0;
    u_mcsr_host.access(1'h0, mcsr_pkg::OFS_SUPPLY_SPEED, 32'h0, rd, er);
    chk("entry", rd, 32'h01F4FFFE);
    u_mcsr_host.access(1'h0, mcsr_pkg::OFS_STATE_SPEED, 32'h0, rd, er);
    chk("selftest", rd, 32'hF0001234);
    u_mcsr_host.access(1'h1, mcsr_pkg::OFS_ALGO_CMD, 32'h80000000, rd, er);
    chk("refused", {26'h0, cmd_o, refused}, 32'h1);
    u_mcsr_host.access(1'h1, mcsr_pkg::OFS_ALGO_CMD, 32'h20000000, rd, er);
    chk("unrefused", {26'h0, cmd_o, refused}, 32'h8);
    // second reset in mid-run must drop the held rate_source_select
    @(negedge clock_i);
    rst_n_i = 1'h0;
    @(negedge clock_i);
    chk("reset", {rate_sel, spd, refused, 15'h0}, 32'h0);
    rst_n_i = 1'h1;
    u_mcsr_host.access(1'h0, mcsr_pkg::OFS_SPEED_RATE_SOURCE_SELECT, 32'h0, rd, er);
    chk("rate_source_select", rd, 32'h0);
    test_done();
  end
endmodule
